// ---- hw/fdps_status_io.v ----
// Fieldbus DP slave: bit-rate detection, cyclic image and indicators.
// Assumes line_rx synchronous to clk; status inputs are levels.
`timescale 1ns/1ps
`include "fdps_consts.vh"
module fdps_status_io (
    input  wire        clk,
    input  wire        reset,
    input  wire        line_rx,
    input  wire        online,
    input  wire        data_exchange,
    input  wire        cfg_mismatch,
    input  wire        module_init_done,
    input  wire        diag_present,
    input  wire        exception_error,
    input  wire        weight_float_sel,
    input  wire [31:0] weight_int,
    input  wire [31:0] weight_float,
    input  wire [31:0] status_dword,
    input  wire        image_strobe,
    input  wire [31:0] plc_out_dw0,
    input  wire [31:0] plc_out_dw1,
    input  wire        plc_out_strobe,
    output reg  [3:0]  rate_code_q,
    output reg         rate_locked_q,
    output reg  [15:0] in_word0_q,
    output reg  [15:0] in_word1_q,
    output reg  [15:0] in_word2_q,
    output reg  [15:0] in_word3_q,
    output reg  [31:0] dev_in_dw0_q,
    output reg  [31:0] dev_in_dw1_q,
    output reg         dev_in_valid_q,
    output reg         op_mode_indicator,
    output reg         op_error_indicator,
    output reg         module_status_indicator,
    output reg         module_error_indicator
);
    ////////////////////////////////////////////////////////////////////////
    // Nominal bit times in clock cycles for the ten bus rates
    function [15:0] fdps_bit_cyc;
        input [3:0] idx;
        begin
            case (idx)
                4'h1: fdps_bit_cyc = 16'h1458;  // 9.6 kbps
                4'h2: fdps_bit_cyc = 16'h0A2C;  // 19.2 kbps
                4'h3: fdps_bit_cyc = 16'h044C;  // 45.45 kbps
                4'h4: fdps_bit_cyc = 16'h0215;  // 93.75 kbps
                4'h5: fdps_bit_cyc = 16'h010B;  // 187.5 kbps
                4'h6: fdps_bit_cyc = 16'h0064;  // 500 kbps
                4'h7: fdps_bit_cyc = 16'h0021;  // 1.5 Mbps
                4'h8: fdps_bit_cyc = 16'h0011;  // 3 Mbps
                4'h9: fdps_bit_cyc = 16'h0008;  // 6 Mbps
                4'hA: fdps_bit_cyc = 16'h0004;  // 12 Mbps
                default: fdps_bit_cyc = 16'hFFFF;
            endcase
        end
    endfunction

    // Classify a measured edge gap as the rate within a quarter of its bit time (lowest gap wins)
    function [3:0] fdps_classify;
        input [15:0] gap;
        reg   [3:0]  k;
        reg   [3:0]  best;
        begin
            best = `FDPS_RATE_NONE;
            for (k = 4'hA; k != 4'h0; k = k - 4'h1) begin
                if (best == `FDPS_RATE_NONE &&
                    gap < fdps_bit_cyc(k) + (fdps_bit_cyc(k) >> 2) &&
                    gap > fdps_bit_cyc(k) - (fdps_bit_cyc(k) >> 2))
                    best = k;
            end
            fdps_classify = best;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Rate hunt: shortest single-bit gap seen, confirmed over several edges
    // The gap counter saturates, so a long idle line never wraps into a
    // short gap and fakes a fast rate. The first edge after reset or after
    // an unlock carries a saturated gap and only counts towards the edges.
    // Silence is measured in whole bit times by a separate counter, since
    // the gap counter passes the nominal bit time only once per idle spell.
    reg        line_q;
    reg [15:0] gap_q;
    reg [15:0] min_gap_q;
    reg [3:0]  edges_q;
    reg [15:0] idle_q;
    reg [15:0] bit_q;
    wire       edge_seen = line_rx ^ line_q;
    wire [3:0] cand      = fdps_classify(min_gap_q);
    wire [15:0] bit_last = fdps_bit_cyc(rate_code_q) - 16'h0001;

    always @(posedge clk) begin
        if (reset) begin
            line_q        <= 1'b1;
            gap_q         <= 16'hFFFF;                                 // Time since edge unknown
            bit_q         <= 16'h0000;
            min_gap_q     <= 16'hFFFF;
            edges_q       <= 4'h0;
            idle_q        <= 16'h0000;
            rate_code_q   <= `FDPS_RATE_NONE;
            rate_locked_q <= 1'b0;
        end else begin
            line_q <= line_rx;
            // Count from one so the gap equals the edge spacing in cycles
            if (edge_seen) begin
                gap_q  <= 16'h0001;
                idle_q <= 16'h0000;
                bit_q  <= 16'h0000;
                if (gap_q < min_gap_q)
                    min_gap_q <= gap_q;
                if (edges_q != `FDPS_LOCK_EDGES)
                    edges_q <= edges_q + 4'h1;
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 16'h0001;
            end
            // Lock once enough edges have set the minimum gap
            if (!rate_locked_q && edges_q == `FDPS_LOCK_EDGES && cand != `FDPS_RATE_NONE) begin
                rate_code_q   <= cand;
                rate_locked_q <= 1'b1;
            end
            // Long silence at the locked rate restarts the hunt; no manual rate
            if (rate_locked_q && !edge_seen) begin
                if (idle_q == `FDPS_IDLE_BITS) begin
                    idle_q        <= 16'h0000;
                    rate_locked_q <= 1'b0;
                    rate_code_q   <= `FDPS_RATE_NONE;
                    min_gap_q     <= 16'hFFFF;
                    edges_q       <= 4'h0;
                    gap_q         <= 16'hFFFF;
                    bit_q         <= 16'h0000;
                end else if (bit_q == bit_last) begin
                    // One whole bit time of silence at the locked rate
                    bit_q  <= 16'h0000;
                    idle_q <= idle_q + 16'h0001;
                end else begin
                    bit_q <= bit_q + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cyclic input image: weight then status, high word first
    wire [31:0] weight_sel = weight_float_sel ? weight_float : weight_int;

    always @(posedge clk) begin
        if (reset) begin
            in_word0_q <= 16'h0000;
            in_word1_q <= 16'h0000;
            in_word2_q <= 16'h0000;
            in_word3_q <= 16'h0000;
        end else if (image_strobe) begin
            in_word0_q <= weight_sel[31:16];
            in_word1_q <= weight_sel[15:0];
            in_word2_q <= status_dword[31:16];
            in_word3_q <= status_dword[15:0];
        end
    end

    // Cyclic output image from the master, taken as a whole pair
    always @(posedge clk) begin
        if (reset) begin
            dev_in_dw0_q   <= 32'h0000_0000;
            dev_in_dw1_q   <= 32'h0000_0000;
            dev_in_valid_q <= 1'b0;
        end else begin
            dev_in_valid_q <= plc_out_strobe;
            if (plc_out_strobe) begin
                dev_in_dw0_q <= plc_out_dw0;
                dev_in_dw1_q <= plc_out_dw1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator cadence; double flash is four phases on/off then a gap
    wire       ph;
    wire       ph_pulse;
    reg  [2:0] seq_q;

    fdps_flasher #(
        .PERIOD (`FDPS_FLASH_CYC)
    ) u_flash (
        .clk     (clk),
        .reset   (reset),
        .phase_q (ph),
        .pulse_q (ph_pulse)
    );

    always @(posedge clk) begin
        if (reset)
            seq_q <= 3'h0;
        else if (ph_pulse)
            seq_q <= seq_q + 3'h1;
    end

    // Slots only advance on the flasher pulse, so all flashing indicators share one cadence
    // Two lit slots out of eight give the double flash pattern
    wire dbl_flash = (seq_q == 3'h0) || (seq_q == 3'h2);

    always @(posedge clk) begin
        if (reset) begin
            op_mode_indicator       <= 1'b0;
            op_error_indicator      <= 1'b0;
            module_status_indicator <= 1'b0;
            module_error_indicator  <= 1'b0;
        end else begin
            op_mode_indicator       <= online & (data_exchange | ph);
            op_error_indicator      <= cfg_mismatch & dbl_flash;
            module_status_indicator <= module_init_done & (~diag_present | ph);
            module_error_indicator  <= exception_error;
        end
    end
endmodule

// ---- hw/fdps_consts.vh ----
// Constants for the fieldbus DP slave status and cyclic image block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef FDPS_CONSTS_VH
`define FDPS_CONSTS_VH
`define FDPS_CLK_HZ         50000000
`define FDPS_RATE_COUNT     10
`define FDPS_RATE_W         4
`define FDPS_RATE_NONE      4'h0
`define FDPS_FLASH_MS       200
`define FDPS_FLASH_CYC      24'h98_9680  // 200 ms at 50 MHz, sized for the divider
`define FDPS_CNT_W          24
`define FDPS_TICK_W         16
`define FDPS_LOCK_EDGES     4'h8
`define FDPS_IDLE_BITS      16'h00C8
`define FDPS_DW_W           32
`define FDPS_WORD_W         16
`endif

// ---- hw/fdps_flasher.v ----
// Flash cadence generator for the status indicators.
// Assumes synchronous reset; one phase toggle per period.
`timescale 1ns/1ps
`include "fdps_consts.vh"
module fdps_flasher #(
    parameter [23:0] PERIOD = `FDPS_FLASH_CYC
) (
    input  wire        clk,
    input  wire        reset,
    output reg         phase_q,
    output reg         pulse_q
);
    reg [`FDPS_CNT_W-1:0] cnt_q;

    // Free running divider; a long period keeps flash distinct from steady
    always @(posedge clk) begin
        if (reset) begin
            cnt_q   <= 24'h00_0000;
            phase_q <= 1'b0;
            pulse_q <= 1'b0;
        end else if (cnt_q == PERIOD - 24'h00_0001) begin
            cnt_q   <= 24'h00_0000;
            phase_q <= ~phase_q;
            pulse_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_q + 24'h00_0001;
            pulse_q <= 1'b0;
        end
    end
endmodule

// ---- tb/fdps_chk.sv ----
// Checker for indicator, image and rate-lock relations.
// Assumes binding to fdps_status_io; one clock, sync reset.
`timescale 1ns/1ps
module fdps_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        online,
    input wire logic        data_exchange,
    input wire logic        cfg_mismatch,
    input wire logic        module_init_done,
    input wire logic        diag_present,
    input wire logic        exception_error,
    input wire logic        plc_out_strobe,
    input wire logic        dev_in_valid_q,
    input wire logic        rate_locked_q,
    input wire logic        op_mode_indicator,
    input wire logic        op_error_indicator,
    input wire logic        module_status_indicator,
    input wire logic        module_error_indicator,
    input wire logic [31:0] plc_out_dw0,
    input wire logic [31:0] dev_in_dw0_q,
    input wire logic [3:0]  rate_code_q
);
    // Lit checks skip the edge after reset, where outputs still read 0
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_mode_dark: assert property (!online |=> !op_mode_indicator) else $error("mode lit");
    a_mode_lit: assert property (!$past(reset) && online && data_exchange
        |=> op_mode_indicator) else $error("mode not lit");
    a_oerr_dark: assert property (!cfg_mismatch |=> !op_error_indicator) else $error("oerr");
    a_stat_dark: assert property (!module_init_done |=> !module_status_indicator)
        else $error("status lit uninit");
    a_stat_lit: assert property (!$past(reset) && module_init_done && !diag_present
        |=> module_status_indicator) else $error("status not lit");
    a_err_dark: assert property (!exception_error |=> !module_error_indicator)
        else $error("error lit");
    a_err_lit: assert property (!$past(reset) && exception_error
        |=> module_error_indicator) else $error("error not lit");
    a_out_pulse: assert property (!$past(reset) && plc_out_strobe
        |=> dev_in_valid_q && dev_in_dw0_q == $past(plc_out_dw0)) else $error("out image");
    a_valid_cause: assert property (dev_in_valid_q |-> $past(plc_out_strobe))
        else $error("stray valid");
    a_lock_code: assert property (rate_locked_q |-> rate_code_q inside {[1:10]})
        else $error("lock without rate");
    a_unlock_code: assert property (!rate_locked_q |-> rate_code_q == 4'h0)
        else $error("rate without lock");
endmodule
bind fdps_status_io fdps_chk u_fdps_chk (.clk, .reset, .online, .data_exchange, .cfg_mismatch,
    .module_init_done, .diag_present, .exception_error, .plc_out_strobe, .dev_in_valid_q,
    .rate_locked_q, .op_mode_indicator, .op_error_indicator, .module_status_indicator,
    .module_error_indicator, .plc_out_dw0, .dev_in_dw0_q, .rate_code_q);

// ---- tb/fdps_plc.sv ----
// Bus master model: drives the bus line and the output image.
// Assumes the bench clock; changes signals on the falling edge.
`timescale 1ns/1ps
module fdps_plc (
    input  wire logic  clk,
    output logic        line_rx,
    output logic [31:0] plc_out_dw0,
    output logic [31:0] plc_out_dw1,
    output logic        plc_out_strobe
);
    initial begin
        line_rx = 1'b1;
        plc_out_dw0 = 32'h0000_0000;
        plc_out_dw1 = 32'h0000_0000;
        plc_out_strobe = 1'b0;
    end
    // Edges spaced gap cycles; silence afterwards
    task automatic toggles(input int gap, input int n);
        repeat (n) begin
            repeat (gap) @(negedge clk);
            line_rx = ~line_rx;
        end
    endtask
    // Whole two-dword image; data scrambled once released
    task automatic send_out(input logic [31:0] d0, input logic [31:0] d1);
        @(negedge clk);
        plc_out_dw0 = d0;
        plc_out_dw1 = d1;
        plc_out_strobe = 1'b1;
        @(negedge clk);
        plc_out_strobe = 1'b0;
        plc_out_dw0 = ~d0;
        plc_out_dw1 = ~d1;
    endtask
endmodule

// ---- tb/fdps_status_io_tb_top.sv ----
// Testbench for fdps_status_io with a bus master model.
// Assumes 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module fdps_status_io_tb_top;
    logic        clk = 1'b0, reset = 1'b1, online = 1'b0, data_exchange = 1'b0;
    logic        cfg_mismatch = 1'b0, module_init_done = 1'b0, diag_present = 1'b0;
    logic        exception_error = 1'b0, weight_float_sel = 1'b0, image_strobe = 1'b0;
    logic [31:0] weight_int = 32'h0, weight_float = 32'h0, status_dword = 32'h0;
    logic        line_rx, plc_out_strobe, rate_locked_q, dev_in_valid_q;
    logic [31:0] plc_out_dw0, plc_out_dw1, dev_in_dw0_q, dev_in_dw1_q;
    logic [15:0] in_word0_q, in_word1_q, in_word2_q, in_word3_q;
    logic [3:0]  rate_code_q;
    logic        op_mode_indicator, op_error_indicator;
    logic        module_status_indicator, module_error_indicator;
    int          failures = 0, comparisons = 0;
    always #10 clk = ~clk;
    fdps_plc u_fdps_plc (.clk, .line_rx, .plc_out_dw0, .plc_out_dw1, .plc_out_strobe);
    fdps_status_io u_fdps_status_io (.clk, .reset, .line_rx, .online, .data_exchange,
        .cfg_mismatch, .module_init_done, .diag_present, .exception_error, .weight_float_sel,
        .weight_int, .weight_float, .status_dword, .image_strobe, .plc_out_dw0, .plc_out_dw1,
        .plc_out_strobe, .rate_code_q, .rate_locked_q, .in_word0_q, .in_word1_q, .in_word2_q,
        .in_word3_q, .dev_in_dw0_q, .dev_in_dw1_q, .dev_in_valid_q, .op_mode_indicator,
        .op_error_indicator, .module_status_indicator, .module_error_indicator);
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Callers sit on a falling edge, so six falling edges give six reset clocks
    task automatic do_reset();
        reset = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b0;
    endtask
    // Level combinations, then flashing states inside their first 200 ms phase:
    // clear and diagnostics still dark, double flash in its first lit slot
    task automatic test_ind();
        logic [5:0] ins [6] = '{6'b00_0000, 6'b11_0000, 6'b00_0100, 6'b00_0001, 6'b11_0101,
            6'b10_1110};
        logic [3:0] exp [6] = '{4'b0000, 4'b1000, 4'b0010, 4'b0001, 4'b1011, 4'b0100};
        for (int i = 0; i < 6; i++) begin
            {online, data_exchange, cfg_mismatch, module_init_done, diag_present,
                exception_error} = ins[i];
            repeat (2) @(negedge clk);
            check("indicators", {op_mode_indicator, op_error_indicator, module_status_indicator,
                module_error_indicator}, exp[i]);
        end
        $display("test_ind done");
    endtask
    // Back-to-back strobes, integer then float coding
    task automatic test_image();
        weight_int = 32'h1234_5678;
        weight_float = 32'h4048_F5C3;
        status_dword = 32'hA5C3_0F96;
        image_strobe = 1'b1;
        @(negedge clk);
        check("weight", {in_word0_q, in_word1_q}, 32'h1234_5678);
        check("status", {in_word2_q, in_word3_q}, 32'hA5C3_0F96);
        weight_float_sel = 1'b1;
        @(negedge clk);
        image_strobe = 1'b0;
        weight_float = 32'h0;
        check("weight", {in_word0_q, in_word1_q}, 32'h4048_F5C3);
        @(negedge clk);
        check("held", {in_word0_q, in_word1_q}, 32'h4048_F5C3);
        $display("test_image done");
    endtask
    task automatic test_out();
        u_fdps_plc.send_out(32'h0F1E_2D3C, 32'hC3B4_A596);
        check("valid", dev_in_valid_q, 1'b1);
        check("dw0", dev_in_dw0_q, 32'h0F1E_2D3C);
        check("dw1", dev_in_dw1_q, 32'hC3B4_A596);
        @(negedge clk);
        check("valid", dev_in_valid_q, 1'b0);
        check("dw0 held", dev_in_dw0_q, 32'h0F1E_2D3C);
        check("dw1 held", dev_in_dw1_q, 32'hC3B4_A596);
        $display("test_out done");
    endtask
    // All ten rates, then silence unlock, then a gap matching none
    // Eight edges leave the line idle high, so no false edge follows reset
    task automatic test_rates();
        int gaps [10] = '{5208, 2604, 1100, 533, 267, 100, 33, 17, 8, 4};
        for (int i = 0; i < 10; i++) begin
            do_reset();
            u_fdps_plc.toggles(gaps[i], 8);
            repeat (3) @(negedge clk);
            check("rate_code", rate_code_q, i + 1);
            check("locked", rate_locked_q, 1'b1);
        end
        repeat (900) @(negedge clk);
        check("unlocked", {rate_locked_q, rate_code_q}, 5'h00);
        do_reset();
        u_fdps_plc.toggles(11, 8);
        repeat (3) @(negedge clk);
        check("refused", rate_locked_q, 1'b0);
        $display("test_rates done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    // Tests need about 80k cycles; limit at 150k
    initial begin
        #3_000_000;
        failures++;
        $display("ERROR watchdog expected done seen hang");
        wrap_up();
    end
    initial begin
        do_reset();
        test_ind();
        test_image();
        test_out();
        test_rates();
        wrap_up();
    end
endmodule
